// File: verilog/cbr_setpoints.sv
/*
 * Setpoint register bank of a bus-programmed battery charger: byte-wise
 * word access from a serial slave engine, DAC code extraction with
 * saturation, trickle override, watchdogs and charge enable.
 * Assumes the serial engine delivers one pulse per command code, data
 * byte, read request and stop, all on mclk; pins are asynchronous.
 */
`timescale 1ns/1ps
module cbr_setpoints
  import cbr_pkg::*;
#(
  parameter longint unsigned WDOG_LIMIT = WDOG_CYCLES,
  parameter longint unsigned SCL_LIMIT  = SCL_CYCLES,
  parameter logic [15:0]     MAKER_ID   = MAKER_CODE_DEF,
  parameter logic [15:0]     PART_ID    = PART_CODE_DEF
) (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire cbr_host_s  host,
  input  wire logic       scl_in,
  input  wire logic       batt_below_low,
  input  wire logic       batt_above_high,
  output logic            cmd_known,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            wr_commit,
  output logic            timeout,
  output logic            trickle_active,
  output cbr_dac_s        dac
);

  localparam int WDOG_W = $clog2(WDOG_LIMIT + 1);
  localparam int SCL_W  = $clog2(SCL_LIMIT + 1);
  localparam logic [WDOG_W-1:0] WDOG_END = WDOG_W'(WDOG_LIMIT - 1);
  localparam logic [SCL_W-1:0]  SCL_END  = SCL_W'(SCL_LIMIT - 1);

  // Current and adapter fields share layout; only the ceiling differs
  function automatic logic [CUR_W-1:0] sat_field(
    input logic [15:0]      word,
    input logic [CUR_W-1:0] ceiling
  );
    logic [CUR_W-1:0] f;
    f = word[CUR_MSB:CUR_LSB];
    if ((|word[15:CUR_MSB+1]) || (f > ceiling)) begin
      sat_field = ceiling;
    end else begin
      sat_field = f;
    end
  endfunction

  logic [15:0]        battery_current_target;
  logic [15:0]        battery_voltage_target;
  logic [15:0]        adapter_current_limit;
  logic [7:0]         code;
  logic [7:0]         low_byte;
  logic [15:0]        wr_word;
  logic               wr_both;
  logic               lo_is_wr;
  cbr_state_e         state;
  cbr_state_e         next_state;
  logic [WDOG_W-1:0]  wdog_cnt;
  logic [SCL_W-1:0]   scl_cnt;
  logic [2:0]         pins;

  cbr_sync #(
    .W   (3),
    .RST (3'b001)
  ) u_sync (
    .mclk (mclk),
    .srst (srst),
    .ce   (ce),
    .d    ({batt_above_high, batt_below_low, scl_in}),
    .q    (pins)
  );

  wire scl_low_s  = ~pins[0];
  wire batt_low_s = pins[1];
  wire batt_ok_s  = pins[2];

  // Code decode
  wire hit_cur   = (code == REG_CUR);
  wire hit_volt  = (code == REG_VOLT);
  wire hit_adp   = (code == REG_ADP);
  wire hit_maker = (code == REG_MAKER);
  wire hit_part  = (code == REG_PART);
  wire cmd_cur   = (host.cmd_code == REG_CUR);
  wire cmd_volt  = (host.cmd_code == REG_VOLT);
  wire cmd_adp   = (host.cmd_code == REG_ADP);
  wire cmd_id    = (host.cmd_code == REG_MAKER) ||
                   (host.cmd_code == REG_PART);

  assign cmd_known = cmd_cur | cmd_volt | cmd_adp | cmd_id;

  wire [15:0] rd_word = hit_cur   ? battery_current_target :
                        hit_volt  ? battery_voltage_target :
                        hit_adp   ? adapter_current_limit  :
                        hit_maker ? MAKER_ID               :
                        hit_part  ? PART_ID                :
                                    16'h0000;

  // Transaction sequencing: a byte advances the state, stop ends it
  wire byte_ev = host.wr_valid | host.rd_req;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = ST_IDLE;
      ST_CODE: if (byte_ev) next_state = ST_LOW;
      ST_LOW:  if (byte_ev) next_state = ST_HIGH;
      ST_HIGH: next_state = ST_HIGH;
      default: next_state = ST_IDLE;
    endcase
    if (host.stop) begin
      next_state = ST_IDLE;
    end
    if (host.cmd_valid) begin
      next_state = ST_CODE;
    end
  end

  // A single write is taken only when both bytes came in as writes
  wire commit = host.stop && (state == ST_HIGH) && wr_both;
  wire wr_cur  = commit && hit_cur;
  wire wr_volt = commit && hit_volt;
  wire wr_adp  = commit && hit_adp;
  wire sp_wr   = wr_cur | wr_volt;

  always_ff @(posedge mclk) begin
    if (srst) begin
      state    <= ST_IDLE;
      code     <= 8'h00;
      low_byte <= 8'h00;
      wr_word  <= 16'h0000;
      wr_both  <= 1'b0;
      lo_is_wr <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      if (host.cmd_valid) begin
        code     <= host.cmd_code;
        wr_both  <= 1'b0;
        lo_is_wr <= 1'b0;
      end else if (host.wr_valid && state == ST_CODE) begin
        low_byte <= host.wr_byte;
        lo_is_wr <= 1'b1;
      end else if (host.wr_valid && state == ST_LOW) begin
        wr_word <= {host.wr_byte, low_byte};
        // A read as first byte would leave a stale low byte here
        wr_both <= lo_is_wr;
      end else if (host.rd_req && state != ST_IDLE) begin
        wr_both <= 1'b0;
      end
    end
  end

  // Read bytes: low first, high second, zero past the word
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else if (ce) begin
      rd_valid <= host.rd_req && !host.cmd_valid && state != ST_IDLE;
      if (host.rd_req) begin
        case (state)
          ST_CODE: rd_data <= rd_word[7:0];
          ST_LOW:  rd_data <= rd_word[15:8];
          default: rd_data <= 8'h00;
        endcase
      end
    end
  end

  // Register file; identification words have no storage at all
  always_ff @(posedge mclk) begin
    if (srst) begin
      battery_current_target <= CUR_RST;
      battery_voltage_target <= VOLT_RST;
      adapter_current_limit  <= ADP_RST;
      wr_commit              <= 1'b0;
    end else if (ce) begin
      wr_commit <= commit && (hit_cur | hit_volt | hit_adp);
      if (wr_cur) begin
        battery_current_target <= wr_word;
      end
      if (wr_volt) begin
        battery_voltage_target <= wr_word;
      end
      if (wr_adp) begin
        adapter_current_limit <= wr_word;
      end
    end
  end

  // Code extraction and saturation
  wire [VOLT_W-1:0] v_field =
    battery_voltage_target[VOLT_MSB:VOLT_LSB];
  wire [VOLT_W-1:0] v_code =
    (v_field > VOLT_CODE_MAX) ? VOLT_CODE_MAX :
    (v_field < VOLT_CODE_MIN) ? '0 : v_field;
  wire [CUR_W-1:0] i_code =
    sat_field(battery_current_target, CUR_CODE_MAX);
  wire [CUR_W-1:0] a_code =
    sat_field(adapter_current_limit, ADP_CODE_MAX);

  // Watchdogs: pulses set the sticky flag; set beats a setpoint write
  wire wdog_hit = (wdog_cnt == WDOG_END);
  wire scl_hit  = scl_low_s && (scl_cnt == SCL_END);

  always_ff @(posedge mclk) begin
    if (srst) begin
      wdog_cnt <= '0;
      scl_cnt  <= '0;
      timeout  <= 1'b0;
    end else if (ce) begin
      if (sp_wr) begin
        wdog_cnt <= '0;
      end else if (wdog_cnt <= WDOG_END) begin
        wdog_cnt <= WDOG_W'(wdog_cnt + 1'b1);
      end
      if (!scl_low_s) begin
        scl_cnt <= '0;
      end else if (scl_cnt <= SCL_END) begin
        scl_cnt <= SCL_W'(scl_cnt + 1'b1);
      end
      if (wdog_hit || scl_hit) begin
        timeout <= 1'b1;
      end else if (sp_wr) begin
        timeout <= 1'b0;
      end
    end
  end

  // Trickle flag with hysteresis; falling below wins over rising above
  always_ff @(posedge mclk) begin
    if (srst) begin
      trickle_active <= 1'b0;
    end else if (ce) begin
      if (batt_low_s) begin
        trickle_active <= 1'b1;
      end else if (batt_ok_s) begin
        trickle_active <= 1'b0;
      end
    end
  end

  wire en_ok = (battery_current_target > CUR_EN_MIN) &&
               (battery_voltage_target > VOLT_EN_MIN) &&
               (v_code != '0) && (i_code != '0) &&
               !timeout;

  always_ff @(posedge mclk) begin
    if (srst) begin
      dac <= '0;
    end else if (ce) begin
      dac.voltage_dac_code <= v_code;
      dac.current_dac_code <= trickle_active ? TRICKLE_CODE
                                             : i_code;
      dac.adapter_dac_code <= a_code;
      dac.charge_enable    <= en_ok;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_write_word(logic [7:0] c, logic [7:0] lo, logic [7:0] hi);
    ce && host.cmd_valid && !host.stop && host.cmd_code == c
    ##1 ce && host.wr_valid && !host.cmd_valid && !host.stop
        && host.wr_byte == lo
    ##1 ce && host.wr_valid && !host.cmd_valid && !host.stop
        && host.wr_byte == hi
    ##1 ce && host.stop && !host.cmd_valid;
  endsequence

  AST_BYTE_ORDER: assert property (
    s_write_word(REG_CUR, 8'hA0, 8'h41) |=>
      battery_current_target == 16'h41A0)
    else $error("current word not assembled low byte first");

  AST_ID_FIXED: assert property (
    ce && state == ST_CODE && hit_maker && host.rd_req
      && !host.cmd_valid |=> rd_data == MAKER_ID[7:0] && rd_valid)
    else $error("maker id low byte wrong");

  AST_RESET_VALUES: assert property (
    $past(srst) |-> battery_current_target == 16'h0000
      && battery_voltage_target == 16'h0000
      && adapter_current_limit == 16'h0080 && !dac.charge_enable)
    else $error("reset values wrong");

  AST_ENABLE_NEEDS_BOTH: assert property (
    dac.charge_enable |-> $past(battery_current_target) > 16'h007F
      && $past(battery_voltage_target) > 16'h000F)
    else $error("charge enabled below thresholds");

  AST_ZERO_DISABLES: assert property (
    ce && (wr_cur || wr_volt) && wr_word == 16'h0000 ##1 ce
      |=> !dac.charge_enable)
    else $error("zero setpoint write left charging on");

  AST_VOLT_SAT: assert property (
    ce && battery_voltage_target[14:4] > 11'd1200
      |=> dac.voltage_dac_code == 11'd1200)
    else $error("voltage code not saturated at 1200");

  AST_VOLT_FLOOR: assert property (
    ce && battery_voltage_target[14:4] < 11'd64 && !wr_volt ##1 ce
      |=> dac.voltage_dac_code == 11'd0 && !dac.charge_enable)
    else $error("voltage below floor not zeroed");

  AST_CUR_SAT: assert property (
    ce && !trickle_active && |battery_current_target[15:13]
      |=> dac.current_dac_code == 6'd63)
    else $error("current code not saturated");

  AST_TRICKLE: assert property (
    ce && trickle_active |=> dac.current_dac_code == 6'd1
      && ($stable(battery_current_target) || $past(wr_cur)))
    else $error("trickle code not applied");

  AST_ADP_SAT: assert property (
    ce && adapter_current_limit[12:7] > 6'd42
      |=> dac.adapter_dac_code == 6'd42)
    else $error("adapter code not saturated at 42");

  AST_TIMEOUT_OFF: assert property (
    ce && wdog_hit ##1 ce |=> !dac.charge_enable)
    else $error("charging survived watchdog expiry");

endmodule // cbr_setpoints

// File: verilog/cbr_pkg.sv
/*
 * Shared constants, states and carriers of the charger setpoint bank.
 * Assumes a 100 MHz logic clock; the watchdog and clock-low cycle counts derive from it.
 */
package cbr_pkg;

  // Register codes
  localparam logic [7:0]  REG_CUR   = 8'h14;
  localparam logic [7:0]  REG_VOLT  = 8'h15;
  localparam logic [7:0]  REG_ADP   = 8'h3F;
  localparam logic [7:0]  REG_MAKER = 8'hFE;
  localparam logic [7:0]  REG_PART  = 8'hFF;

  // Reset values
  localparam logic [15:0] CUR_RST   = 16'h0000;
  localparam logic [15:0] VOLT_RST  = 16'h0000;
  localparam logic [15:0] ADP_RST   = 16'h0080;

  // Identification words: values are arbitrary
  localparam logic [15:0] MAKER_CODE_DEF = 16'h5A3C;
  localparam logic [15:0] PART_CODE_DEF  = 16'h0102;

  // Field layout
  localparam int VOLT_LSB = 4;
  localparam int VOLT_MSB = 14;
  localparam int VOLT_W   = 11;
  localparam int CUR_LSB  = 7;
  localparam int CUR_MSB  = 12;
  localparam int CUR_W    = 6;

  // Scaling and limits
  localparam int VOLT_STEP_MV = 16;
  localparam int VOLT_MAX_MV  = 19200;
  localparam int VOLT_MIN_MV  = 1024;
  localparam int CUR_STEP_MA  = 128;
  localparam int CUR_MAX_MA   = 8064;
  localparam int TRICKLE_MA   = 128;
  localparam int ADP_STEP_MA  = 256;
  localparam int ADP_MAX_MA   = 11004;
  localparam logic [VOLT_W-1:0] VOLT_CODE_MAX =
    VOLT_W'(VOLT_MAX_MV / VOLT_STEP_MV);
  localparam logic [VOLT_W-1:0] VOLT_CODE_MIN =
    VOLT_W'(VOLT_MIN_MV / VOLT_STEP_MV);
  localparam logic [CUR_W-1:0]  CUR_CODE_MAX  =
    CUR_W'(CUR_MAX_MA / CUR_STEP_MA);
  localparam logic [CUR_W-1:0]  TRICKLE_CODE  =
    CUR_W'(TRICKLE_MA / CUR_STEP_MA);
  localparam logic [CUR_W-1:0]  ADP_CODE_MAX  =
    CUR_W'(ADP_MAX_MA / ADP_STEP_MA);

  // Enable thresholds on the raw register words
  localparam logic [15:0] CUR_EN_MIN  = 16'h007F;
  localparam logic [15:0] VOLT_EN_MIN = 16'h000F;

  // Timing
  localparam longint unsigned CLK_PERIOD_NS   = 10;
  localparam longint unsigned WDOG_TIME_S     = 175;
  localparam longint unsigned SCL_LOW_TIME_MS = 25;
  localparam longint unsigned WDOG_CYCLES =
    WDOG_TIME_S * 64'd1000000000 / CLK_PERIOD_NS;
  localparam longint unsigned SCL_CYCLES =
    SCL_LOW_TIME_MS * 64'd1000000 / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CODE = 4'b0010,
    ST_LOW  = 4'b0100,
    ST_HIGH = 4'b1000
  } cbr_state_e;

  typedef struct packed {
    logic       cmd_valid;
    logic [7:0] cmd_code;
    logic       wr_valid;
    logic [7:0] wr_byte;
    logic       rd_req;
    logic       stop;
  } cbr_host_s;

  typedef struct packed {
    logic [VOLT_W-1:0] voltage_dac_code;
    logic [CUR_W-1:0]  current_dac_code;
    logic [CUR_W-1:0]  adapter_dac_code;
    logic              charge_enable;
  } cbr_dac_s;

endpackage

// File: verilog/cbr_sync.sv
/*
 * Two-flop level synchroniser for pin inputs.
 * Assumes each bit is a slow level; no relation between bits is kept.
 */
`timescale 1ns/1ps
module cbr_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk) begin
    if (srst) begin
      meta <= RST;
      q    <= RST;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // cbr_sync

// File: tb/cbr_host_model.sv
/*
 * Bus host model for the charger setpoint bank: command, data, read and
 * stop pulses as the serial slave engine would hand them over.
 * Assumes the bank samples on the rising edge; all driving is on the fall.
 */
`timescale 1ns/1ps
module cbr_host_model
  import cbr_pkg::*;
(
  input  wire logic mclk,
  output cbr_host_s host
);
  initial host = '0;

  // Released qualifiers never keep their last value
  function automatic cbr_host_s quiet();
    quiet          = '0;
    quiet.cmd_code = ~host.cmd_code;
    quiet.wr_byte  = ~host.wr_byte;
  endfunction

  task automatic step(input cbr_host_s v, input int gap);
    @(negedge mclk);
    host = v;
    repeat (gap) begin
      @(negedge mclk);
      host = quiet();
    end
  endtask

  // One transaction: code, up to two data bytes or two read requests, stop
  task automatic word(input logic [7:0] code, input logic [15:0] data,
                      input int nwr, input bit rd, input int gap);
    cbr_host_s v;
    v = quiet();
    v.cmd_valid = 1'b1;
    v.cmd_code  = code;
    step(v, gap);
    for (int i = 0; i < nwr; i++) begin
      v = quiet();
      v.wr_valid = 1'b1;
      v.wr_byte  = (i == 0) ? data[7:0] : data[15:8];
      step(v, gap);
    end
    if (rd) begin
      repeat (2) begin
        v = quiet();
        v.rd_req = 1'b1;
        step(v, gap);
      end
    end
    v = quiet();
    v.stop = 1'b1;
    step(v, 0);
    step(quiet(), 0);
  endtask
endmodule // cbr_host_model

// File: tb/tb_top.sv
/*
 * Self-checking bench for the charger setpoint bank.
 * Assumes shortened watchdog and clock-low limits set at the instance.
 */
`timescale 1ns/1ps
module tb_top;
  import cbr_pkg::*;
  localparam longint unsigned WDOG = 1500;
  localparam longint unsigned SCLL = 50;

  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  logic       ce = 1'b1;
  logic       scl_in = 1'b1;
  logic       batt_below_low = 1'b0;
  logic       batt_above_high = 1'b0;
  cbr_host_s  host;
  logic       cmd_known;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic       wr_commit;
  logic       timeout;
  logic       trickle_active;
  cbr_dac_s   dac;
  int         n_mismatch = 0;
  int         compares = 0;
  int         cycles = 0;
  int         seed = 93;
  logic [7:0] rd_q[$];
  cbr_dac_s   dac_q[$];
  logic [15:0] cur_m = CUR_RST;
  logic [15:0] volt_m = VOLT_RST;
  logic [15:0] adp_m = ADP_RST;
  bit         to_m = 0;
  bit         commit_seen = 0;

  initial begin
    forever #5 mclk = ~mclk;
  end

  cbr_host_model u_cbr_host_model (.mclk(mclk), .host(host));

  cbr_setpoints #(.WDOG_LIMIT(WDOG), .SCL_LIMIT(SCLL)) u_cbr_setpoints (
    .mclk(mclk), .srst(srst), .ce(ce), .host(host), .scl_in(scl_in),
    .batt_below_low(batt_below_low), .batt_above_high(batt_above_high),
    .cmd_known(cmd_known), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_commit(wr_commit), .timeout(timeout),
    .trickle_active(trickle_active), .dac(dac)
  );

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("mismatches %0d, comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [5:0] cur_field();
    return (|cur_m[15:13]) ? CUR_CODE_MAX : cur_m[12:7];
  endfunction

  function automatic cbr_dac_s exp_dac(input bit trick);
    logic [10:0] vf;
    logic [5:0]  af;
    vf = volt_m[14:4];
    af = adp_m[12:7];
    exp_dac.voltage_dac_code = (vf > VOLT_CODE_MAX) ? VOLT_CODE_MAX :
                               (vf < VOLT_CODE_MIN) ? '0 : vf;
    exp_dac.current_dac_code = trick ? TRICKLE_CODE : cur_field();
    exp_dac.adapter_dac_code = (|adp_m[15:13] || af > ADP_CODE_MAX) ?
                               ADP_CODE_MAX : af;
    exp_dac.charge_enable = cur_m > CUR_EN_MIN && volt_m > VOLT_EN_MIN &&
      exp_dac.voltage_dac_code != '0 && cur_field() != '0 && !to_m;
  endfunction

  function automatic logic [15:0] reg_val(input logic [7:0] code);
    case (code)
      REG_CUR:   return cur_m;
      REG_VOLT:  return volt_m;
      REG_ADP:   return adp_m;
      REG_MAKER: return MAKER_CODE_DEF;
      REG_PART:  return PART_CODE_DEF;
      default:   return 16'h0000;
    endcase
  endfunction

  task automatic wr(input logic [7:0] code, input logic [15:0] d,
                    input int gap);
    if (code == REG_CUR || code == REG_VOLT) to_m = 0;
    if (code == REG_CUR) cur_m = d;
    if (code == REG_VOLT) volt_m = d;
    if (code == REG_ADP) adp_m = d;
    if (code == REG_CUR || code == REG_VOLT || code == REG_ADP)
      dac_q.push_back(exp_dac(0));
    u_cbr_host_model.word(code, d, 2, 0, gap);
  endtask

  task automatic rd(input logic [7:0] code, input int gap);
    logic [15:0] v;
    v = reg_val(code);
    rd_q.push_back(v[7:0]);
    rd_q.push_back(v[15:8]);
    u_cbr_host_model.word(code, 16'h0000, 0, 1, gap);
  endtask

  // Scoreboard: reads pop on rd_valid, codes pop the cycle after a commit
  always @(negedge mclk) begin
    if (rd_valid === 1'b1) begin
      if (rd_q.size() == 0) check(24'h1, 24'h0);
      else check(rd_data, rd_q.pop_front());
    end
    if (commit_seen) begin
      if (dac_q.size() == 0) check(24'h1, 24'h0);
      else check(dac, dac_q.pop_front());
    end
    commit_seen = (wr_commit === 1'b1);
  end

  always @(posedge mclk) begin
    if (host.cmd_valid === 1'b1)
      check(cmd_known, host.cmd_code inside
            {REG_CUR, REG_VOLT, REG_ADP, REG_MAKER, REG_PART});
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end

  logic [7:0]  codes[15] = '{8'h14, 8'h15, 8'h15, 8'h15, 8'h14, 8'h14,
    8'h15, 8'h15, 8'h14, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h14, 8'h14};
  logic [15:0] words[15] = '{16'h0080, 16'h0010, 16'h03F0, 16'h0400,
    16'h007F, 16'h0080, 16'h7FF0, 16'hA000, 16'hFFFF, 16'h1F80, 16'h2000,
    16'h0000, 16'h0580, 16'h0000, 16'h0D00};

  initial begin
    logic [7:0] rc;
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    repeat (2) @(negedge mclk);
    check(dac, exp_dac(0));
    foreach (codes[i]) rd(i < 5 ? codes[i] : 8'h20, 0);
    rd(REG_ADP, 1);
    rd(REG_MAKER, 0);
    rd(REG_PART, 2);
    wr(REG_MAKER, 16'h1234, 0);
    wr(REG_PART, 16'hFFFF, 1);
    rd(REG_MAKER, 0);
    rd(REG_PART, 0);
    // Boundaries of the enable thresholds, floors and ceilings
    foreach (codes[i]) begin
      wr(codes[i], words[i], i % 3);
      rd(codes[i], 0);
    end
    u_cbr_host_model.word(REG_CUR, 16'h1234, 1, 0, 0);
    rd(REG_CUR, 0);
    wr(REG_CUR, 16'h41A0, 0);
    for (int i = 0; i < 24; i++) begin
      rc = (i % 3 == 0) ? REG_CUR : (i % 3 == 1) ? REG_VOLT : REG_ADP;
      wr(rc, 16'($random(seed)), ($random(seed) & 3) % 3);
      rd(rc, 1);
    end
    wr(REG_CUR, 16'h0880, 0);
    wr(REG_VOLT, 16'h3000, 0);
    // Low battery overrides the applied code but keeps the register
    batt_below_low = 1'b1;
    for (int i = 0; i < 10 && trickle_active !== 1'b1; i++) @(negedge mclk);
    check(trickle_active, 1'b1);
    repeat (2) @(negedge mclk);
    check(dac, exp_dac(1));
    rd(REG_CUR, 0);
    // Hysteresis: leaving the low band alone keeps the override
    batt_below_low = 1'b0;
    repeat (6) @(negedge mclk);
    check(trickle_active, 1'b1);
    batt_above_high = 1'b1;
    for (int i = 0; i < 10 && trickle_active !== 1'b0; i++) @(negedge mclk);
    check(trickle_active, 1'b0);
    repeat (2) @(negedge mclk);
    check(dac, exp_dac(0));
    batt_above_high = 1'b0;
    // Watchdog expiry, then only a setpoint write restores charging
    for (int i = 0; i < 1600 && timeout !== 1'b1; i++) @(negedge mclk);
    check(timeout, 1'b1);
    to_m = 1;
    repeat (2) @(negedge mclk);
    check(dac, exp_dac(0));
    wr(REG_ADP, 16'h0300, 0);
    wr(REG_CUR, 16'h0900, 0);
    check(timeout, 1'b0);
    scl_in = 1'b0;
    for (int i = 0; i < 80 && timeout !== 1'b1; i++) @(negedge mclk);
    check(timeout, 1'b1);
    scl_in = 1'b1;
    to_m = 1;
    repeat (2) @(negedge mclk);
    check(dac, exp_dac(0));
    wr(REG_VOLT, 16'h4000, 1);
    repeat (4) @(negedge mclk);
    check(rd_q.size(), 24'h0);
    check(dac_q.size(), 24'h0);
    results();
  end
endmodule // tb_top
